// ---- include/pbs_pkg.sv ----
// Constants for the basic status and identifier register block.
// Assumes a single 40 MHz system clock that oversamples the management link.
package pbs_pkg;

   // Register addresses on the management link
   localparam logic [4:0] BASIC_STATUS_ADDR = 5'h01;
   localparam logic [4:0] IDENTIFIER_HIGH_ADDR = 5'h02;

   // Basic status: reset value holds every constant capability bit
   localparam logic [15:0] BASIC_STATUS_RESET = 16'h7849;
   localparam int T4_CAPABLE_BIT = 15;
   localparam int CAP_TOP_BIT = 14;
   localparam int CAP_LOW_BIT = 11;
   localparam int RESERVED_TOP_BIT = 10;
   localparam int RESERVED_LOW_BIT = 7;
   localparam int PREAMBLE_SKIP_CAPABLE_BIT = 6;
   localparam int AN_COMPLETE_BIT = 5;
   localparam int REMOTE_FAULT_BIT = 4;
   localparam int AN_ABILITY_BIT = 3;
   localparam int LINK_STATUS_BIT = 2;
   localparam int JABBER_BIT = 1;
   localparam int EXTENDED_CAP_BIT = 0;

   // Frame fields
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [5:0] PREAMBLE_BITS = 6'h20;
   localparam logic [4:0] ADDR_BITS = 5'h0a;
   localparam logic [4:0] DATA_BITS = 5'h10;

   // Sticky flag indices
   localparam int FLAG_REMOTE_FAULT = 0;
   localparam int FLAG_JABBER = 1;
   localparam int FLAG_COUNT = 2;

   // Width of the synchronised input bundle
   localparam int SYNC_WIDTH = 11;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_OPCODE,
      ST_ADDR,
      ST_TA1,
      ST_TA2,
      ST_DATA
   } pbs_state_type;

endpackage

// ---- hw/pbs_sync.sv ----
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes each bit changes slowly against the clock; no bus coherence.
`timescale 1ns/1ps
module pbs_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

// ---- hw/pbs_sticky.sv ----
// One sticky status flag: set by an event, cleared by a read.
// Assumes set and clear come from the same clock domain.
`timescale 1ns/1ps
module pbs_sticky (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Control
   input wire logic set_in,
   input wire logic clear_in,
   // State
   output logic flag
);

   // Set beats clear so an event landing on the read is not lost
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         flag <= 1'b0;
      end else if (set_in) begin
         flag <= 1'b1;
      end else if (clear_in) begin
         flag <= 1'b0;
      end
   end

endmodule

// ---- hw/pbs_regs.sv ----
// Management-link slave holding the basic status and identifier registers.
// Assumes mdc well below the 40 MHz clock; all pins arrive asynchronously.
// Summary of operation
// - Four-pair 100 Mbps capability bit reads zero
// - Status bits 14 to 11 read one
// - Preamble-skip capable bit 6 reads one
// - Full preamble after reset or bad frame
// - Bit 5 shows negotiation finished only
// - Remote fault sticky, cleared by read/reset
// - Bit 3 reports negotiation ability, reads one
// - Bit 2 shows valid link present
// - Bit 1 reports jabber detected
// - Bit 0 reports extended registers, reads one
// - Identifier high returns unique identifier bits
`timescale 1ns/1ps
module pbs_regs
   import pbs_pkg::*;
#(
   // Arbitrary neutral value, not any maker's code
   parameter logic [15:0] IDENTIFIER_HIGH_VALUE = 16'h0a5c
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Management link
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   // Station address strap
   input wire logic [4:0] phy_address,
   // Status sources from the line side
   input wire logic an_complete,
   input wire logic link_up,
   input wire logic remote_fault_event,
   input wire logic jabber_event
);

   logic [SYNC_WIDTH-1:0] sync_bus;
   logic mdc_s;
   logic mdio_s;
   logic [4:0] address_s;
   logic an_s;
   logic link_s;
   logic [FLAG_COUNT-1:0] flag_set;
   logic [FLAG_COUNT-1:0] flag_clear;
   logic [FLAG_COUNT-1:0] flag_state;
   logic mdc_prev_reg;
   logic mdc_rise;
   pbs_state_type state_reg;
   logic [5:0] ones_reg;
   logic [4:0] count_reg;
   logic need_preamble_reg;
   logic [1:0] op_reg;
   logic [9:0] addr_reg;
   logic [15:0] shift_reg;
   logic read_clear_reg;
   logic [15:0] status_word;
   logic [15:0] read_word;
   logic addressed;
   logic [1:0] op_now;
   logic preamble_ok;
   logic bad_opcode;
   logic bad_turnaround;
   logic frame_done;

   pbs_sync #(
      .WIDTH(SYNC_WIDTH)
   ) u_sync (
      .clock(clock),
      .reset_n(reset_n),
      .async_in({mdc, mdio_in, an_complete, link_up, remote_fault_event,
                 jabber_event, phy_address}),
      .sync_out(sync_bus)
   );

   assign mdc_s = sync_bus[10];
   assign mdio_s = sync_bus[9];
   assign an_s = sync_bus[8];
   assign link_s = sync_bus[7];
   assign address_s = sync_bus[4:0];

   // Sticky flags: remote fault and jabber, both cleared by a status read
   assign flag_set[FLAG_REMOTE_FAULT] = sync_bus[6];
   assign flag_set[FLAG_JABBER] = sync_bus[5];

   genvar g;
   generate
      for (g = 0; g < FLAG_COUNT; g++) begin : g_flag
         assign flag_clear[g] = read_clear_reg;
         pbs_sticky u_sticky (
            .clock(clock),
            .reset_n(reset_n),
            .set_in(flag_set[g]),
            .clear_in(flag_clear[g]),
            .flag(flag_state[g])
         );
      end
   endgenerate

   // Status word: constant capabilities from the reset pattern, live bits
   always_comb begin
      status_word = BASIC_STATUS_RESET;
      status_word[T4_CAPABLE_BIT] = 1'b0;
      status_word[RESERVED_TOP_BIT:RESERVED_LOW_BIT] = 4'h0;
      status_word[AN_COMPLETE_BIT] = an_s;
      status_word[REMOTE_FAULT_BIT] = flag_state[FLAG_REMOTE_FAULT];
      status_word[LINK_STATUS_BIT] = link_s;
      status_word[JABBER_BIT] = flag_state[FLAG_JABBER];
   end

   // Unmapped addresses read zero
   always_comb begin
      unique case (addr_reg[4:0])
         BASIC_STATUS_ADDR: read_word = status_word;
         IDENTIFIER_HIGH_ADDR: read_word = IDENTIFIER_HIGH_VALUE;
         default: read_word = 16'h0000;
      endcase
   end

   assign addressed = (addr_reg[9:5] == address_s);

   // Frame checks on the bit sampled at the current mdc rise
   assign op_now = {op_reg[0], mdio_s};
   assign preamble_ok = !need_preamble_reg || ones_reg == PREAMBLE_BITS;
   assign bad_opcode = state_reg == ST_OPCODE && count_reg == 5'h01 &&
                       op_now != OP_READ && op_now != OP_WRITE;
   assign bad_turnaround = op_reg == OP_WRITE &&
                           ((state_reg == ST_TA1 && !mdio_s) ||
                            (state_reg == ST_TA2 && mdio_s));
   assign frame_done = state_reg == ST_DATA &&
                       count_reg == DATA_BITS - 5'h01;

   // Edge finder on the second synchroniser stage only
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         mdc_prev_reg <= 1'b0;
      end else begin
         mdc_prev_reg <= mdc_s;
      end
   end

   assign mdc_rise = mdc_s & ~mdc_prev_reg;

   // Frame state, advanced once per mdc rising edge
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_reg <= ST_IDLE;
      end else if (mdc_rise) begin
         unique case (state_reg)
            ST_IDLE: begin
               // A zero after enough preamble is the first start bit
               if (!mdio_s && preamble_ok) begin
                  state_reg <= ST_START;
               end
            end
            ST_START: begin
               state_reg <= mdio_s ? ST_OPCODE : ST_IDLE;
            end
            ST_OPCODE: begin
               if (bad_opcode) begin
                  state_reg <= ST_IDLE;
               end else if (count_reg == 5'h01) begin
                  state_reg <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               if (count_reg == ADDR_BITS - 5'h01) begin
                  state_reg <= ST_TA1;
               end
            end
            ST_TA1: begin
               state_reg <= bad_turnaround ? ST_IDLE : ST_TA2;
            end
            ST_TA2: begin
               state_reg <= bad_turnaround ? ST_IDLE : ST_DATA;
            end
            ST_DATA: begin
               if (frame_done) begin
                  state_reg <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Preamble demand: armed by reset or a bad frame, lifted by a clean one
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         need_preamble_reg <= 1'b1;
      end else if (mdc_rise) begin
         if (bad_opcode || bad_turnaround) begin
            need_preamble_reg <= 1'b1;
         end else if (frame_done) begin
            need_preamble_reg <= 1'b0;
         end
      end
   end

   // Saturating count of idle ones; any zero or frame bit restarts it
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ones_reg <= 6'h00;
      end else if (mdc_rise) begin
         if (state_reg != ST_IDLE || !mdio_s) begin
            ones_reg <= 6'h00;
         end else if (ones_reg != PREAMBLE_BITS) begin
            ones_reg <= ones_reg + 6'h01;
         end
      end
   end

   // Bit counter within the opcode, address and data fields
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         count_reg <= 5'h00;
      end else if (mdc_rise) begin
         unique case (state_reg)
            ST_OPCODE: begin
               if (count_reg == 5'h01) begin
                  count_reg <= 5'h00;
               end else begin
                  count_reg <= count_reg + 5'h01;
               end
            end
            ST_ADDR, ST_DATA: begin
               count_reg <= count_reg + 5'h01;
            end
            default: begin
               count_reg <= 5'h00;
            end
         endcase
      end
   end

   // Opcode shifter, msb first
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         op_reg <= 2'h0;
      end else if (mdc_rise && state_reg == ST_OPCODE) begin
         op_reg <= op_now;
      end
   end

   // Station and register address shifter, msb first
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         addr_reg <= 10'h000;
      end else if (mdc_rise && state_reg == ST_ADDR) begin
         addr_reg <= {addr_reg[8:0], mdio_s};
      end
   end

   // Read data shifter; write data is sampled and dropped
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         shift_reg <= 16'h0000;
      end else if (mdc_rise) begin
         if (state_reg == ST_TA1) begin
            shift_reg <= read_word;
         end else if (state_reg == ST_TA2 || state_reg == ST_DATA) begin
            shift_reg <= {shift_reg[14:0], 1'b0};
         end
      end
   end

   // Clear-on-read pulse when the status word is captured for a read
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         read_clear_reg <= 1'b0;
      end else begin
         read_clear_reg <= mdc_rise && state_reg == ST_TA1 &&
                           op_reg == OP_READ && addressed &&
                           addr_reg[4:0] == BASIC_STATUS_ADDR;
      end
   end

   // Pin drive: zero in the second turnaround bit, then data msb first
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         mdio_out <= 1'b1;
         mdio_oe <= 1'b0;
      end else if (mdc_rise) begin
         unique case (state_reg)
            // An undriven pin keeps showing one, whatever the frame holds
            ST_TA1: begin
               mdio_oe <= op_reg == OP_READ && addressed;
               mdio_out <= !(op_reg == OP_READ && addressed);
            end
            ST_TA2: begin
               mdio_out <= shift_reg[15] | ~mdio_oe;
            end
            ST_DATA: begin
               mdio_out <= shift_reg[15] | ~mdio_oe;
               if (count_reg == DATA_BITS - 5'h01) begin
                  mdio_oe <= 1'b0;
                  mdio_out <= 1'b1;
               end
            end
            default: begin
               mdio_oe <= 1'b0;
               mdio_out <= 1'b1;
            end
         endcase
      end
   end

endmodule

// ---- dv/pbs_smi_master.sv ----
// Station management controller model for the link pins.
// Assumes mdio is the resolved wire, pulled up when nobody drives.
`timescale 1ns/1ps
module pbs_smi_master (
   // Clock
   input wire logic clock,
   // Link pins
   input wire logic mdio,
   output logic mdc,
   output logic mdio_drv
);
   initial begin
      mdc = 1'b0;
      mdio_drv = 1'b1;
   end
   // One bit: data set at the fall, wire sampled at the rise
   task automatic bit_t(input logic b, output logic s);
      repeat (4) @(posedge clock);
      #2 mdc = 1'b0;
      mdio_drv = b;
      repeat (4) @(posedge clock);
      #2 s = mdio;
      mdc = 1'b1;
   endtask
   task automatic xfer(input int npre, input logic [1:0] op,
      input logic [4:0] pa, input logic [4:0] ra, input logic [1:0] ta,
      input logic [15:0] wd, output logic [15:0] rd);
      logic s;
      logic [13:0] hdr;
      hdr = {2'b01, op, pa, ra};
      repeat (20) @(posedge clock);
      bit_t(1'b1, s);
      for (int i = 0; i < npre; i++) bit_t(1'b1, s);
      for (int i = 13; i >= 0; i--) bit_t(hdr[i], s);
      bit_t(ta[1], s);
      bit_t(ta[0], s);
      for (int i = 15; i >= 0; i--) begin
         bit_t(wd[i], s);
         rd[i] = s;
      end
      // Clock parks low between frames
      repeat (4) @(posedge clock);
      #2 mdc = 1'b0;
      mdio_drv = 1'b1;
   endtask
endmodule

// ---- dv/pbs_regs_asserts.sv ----
// Checker for the link pins of the status register block.
// Assumes mdc is far slower than clock; bound onto every pbs_regs.
`timescale 1ns/1ps
module pbs_regs_asserts
   import pbs_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Link and strap
   input wire logic mdc,
   input wire logic mdio_in,
   input wire logic mdio_out,
   input wire logic mdio_oe,
   input wire logic [4:0] phy_address
);
   logic mdc_q;
   logic [2:0] lag;
   logic [4:0] nrise;
   logic [12:0] sh;
   wire rise = mdc && !mdc_q;
   // Raw edge seen here leads the design's view by its sync stages
   always_ff @(posedge clock) begin
      mdc_q <= mdc;
      if (!reset_n) lag <= 3'h7;
      else if (rise) lag <= 3'h0;
      else if (lag != 3'h7) lag <= lag + 3'h1;
   end
   always_ff @(posedge clock) begin
      if (!mdio_oe) nrise <= 5'h00;
      else if (rise) nrise <= nrise + 5'h01;
   end
   always_ff @(posedge clock) begin
      if (rise) sh <= {sh[11:0], mdio_in};
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   a_quiet_reset: assert property ($rose(reset_n) |-> !mdio_oe)
      else $error("driving right after reset");
   a_idle_high: assert property (!mdio_oe |-> mdio_out)
      else $error("undriven output not high");
   a_ta_zero: assert property ($rose(mdio_oe) |-> !mdio_out)
      else $error("turnaround bit not zero");
   a_oe_lag: assert property ($rose(mdio_oe) |-> lag inside {[1:6]})
      else $error("drive start not tied to mdc rise");
   a_out_lag: assert property ($changed(mdio_out) |-> lag inside {[1:6]})
      else $error("output bit changed away from mdc rise");
   a_read_len: assert property ($fell(mdio_oe) |-> nrise == 5'h11)
      else $error("read drive not seventeen bits");
   a_read_max: assert property (mdio_oe |-> nrise <= 5'h11)
      else $error("read drive too long");
   a_addr_ok: assert property ($rose(mdio_oe) |->
      sh[12:11] == OP_READ && sh[10:6] == phy_address)
      else $error("drive without matching read header");
endmodule
bind pbs_regs pbs_regs_asserts chk_u (.clock(clock), .reset_n(reset_n),
   .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
   .mdio_oe(mdio_oe), .phy_address(phy_address));

// ---- dv/test_pbs_regs.sv ----
// Self-checking bench for the status and identifier register block.
// Assumes the controller model and the bound checker are compiled too.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   $display("BAD %s exp %h got %h", n, e, g); mismatches++; end end
module test_pbs_regs
   import pbs_pkg::*;
;
   // Arbitrary value, not any maker's code
   localparam logic [15:0] ID_VALUE = 16'h5a3c;
   localparam logic [4:0] PA = 5'h05;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic an_complete = 1'b0;
   logic link_up = 1'b0;
   logic remote_fault_event = 1'b0;
   logic jabber_event = 1'b0;
   logic mdc, mdio_drv, mdio_out, mdio_oe;
   logic [15:0] rd;
   int mismatches = 0;
   int cmp_count = 0;
   wire mdio = mdio_oe ? mdio_out : mdio_drv;
   always #12.5 clock = ~clock;
   pbs_regs #(.IDENTIFIER_HIGH_VALUE(ID_VALUE)) dut_u (.clock(clock),
      .reset_n(reset_n), .mdc(mdc), .mdio_in(mdio), .mdio_out(mdio_out),
      .mdio_oe(mdio_oe), .phy_address(PA), .an_complete(an_complete),
      .link_up(link_up), .remote_fault_event(remote_fault_event),
      .jabber_event(jabber_event));
   pbs_smi_master mgr_u (.clock(clock), .mdio(mdio), .mdc(mdc),
      .mdio_drv(mdio_drv));
   task automatic set_in(input logic [3:0] v);
      @(posedge clock);
      #2 {an_complete, link_up, remote_fault_event, jabber_event} = v;
   endtask
   task automatic rd_reg(input int np, input logic [4:0] pa,
      input logic [4:0] ra, output logic [15:0] v);
      mgr_u.xfer(np, OP_READ, pa, ra, 2'b11, 16'hffff, v);
   endtask
   task automatic t_fixed();
      rd_reg(32, PA, BASIC_STATUS_ADDR, rd);
      `CHK("status", 16'h7849, rd)
      rd_reg(0, PA, IDENTIFIER_HIGH_ADDR, rd);
      `CHK("ident", ID_VALUE, rd)
      rd_reg(0, PA, 5'h1f, rd);
      `CHK("unmapped", 16'h0000, rd)
   endtask
   task automatic t_live();
      set_in(4'hc);
      rd_reg(0, PA, BASIC_STATUS_ADDR, rd);
      `CHK("live on", 16'h786d, rd)
      set_in(4'h8);
      rd_reg(0, PA, BASIC_STATUS_ADDR, rd);
      `CHK("an only", 16'h7869, rd)
      set_in(4'h0);
      rd_reg(0, PA, BASIC_STATUS_ADDR, rd);
      `CHK("live off", 16'h7849, rd)
   endtask
   task automatic t_sticky();
      set_in(4'h3);
      repeat (4) @(posedge clock);
      set_in(4'h0);
      // A read for another station must not clear the flags
      rd_reg(0, 5'h06, BASIC_STATUS_ADDR, rd);
      `CHK("other station", 16'hffff, rd)
      rd_reg(0, PA, BASIC_STATUS_ADDR, rd);
      `CHK("sticky set", 16'h785b, rd)
      rd_reg(0, PA, BASIC_STATUS_ADDR, rd);
      `CHK("sticky clear", 16'h7849, rd)
      set_in(4'h1);
      repeat (4) @(posedge clock);
      set_in(4'h0);
      rd_reg(0, PA, BASIC_STATUS_ADDR, rd);
      `CHK("jabber only", 16'h784b, rd)
   endtask
   task automatic t_write();
      mgr_u.xfer(0, OP_WRITE, PA, BASIC_STATUS_ADDR, 2'b10, 16'h0000, rd);
      mgr_u.xfer(0, OP_WRITE, PA, IDENTIFIER_HIGH_ADDR, 2'b10, 16'hffff, rd);
      rd_reg(0, PA, BASIC_STATUS_ADDR, rd);
      `CHK("status kept", 16'h7849, rd)
      rd_reg(0, PA, IDENTIFIER_HIGH_ADDR, rd);
      `CHK("ident kept", ID_VALUE, rd)
   endtask
   task automatic t_bad();
      mgr_u.xfer(0, 2'b00, PA, BASIC_STATUS_ADDR, 2'b11, 16'h0000, rd);
      rd_reg(0, PA, BASIC_STATUS_ADDR, rd);
      `CHK("after bad op", 16'hffff, rd)
      rd_reg(32, PA, BASIC_STATUS_ADDR, rd);
      `CHK("preamble again", 16'h7849, rd)
      mgr_u.xfer(0, OP_WRITE, PA, BASIC_STATUS_ADDR, 2'b00, 16'h0000, rd);
      rd_reg(0, PA, BASIC_STATUS_ADDR, rd);
      `CHK("after bad ta", 16'hffff, rd)
   endtask
   task automatic t_reset();
      set_in(4'h2);
      repeat (4) @(posedge clock);
      set_in(4'h0);
      #0 reset_n = 1'b0;
      repeat (3) @(posedge clock);
      #2 reset_n = 1'b1;
      rd_reg(0, PA, BASIC_STATUS_ADDR, rd);
      `CHK("no preamble", 16'hffff, rd)
      rd_reg(32, PA, BASIC_STATUS_ADDR, rd);
      `CHK("reset clears", 16'h7849, rd)
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clock);
      #2 reset_n = 1'b1;
      t_fixed();
      t_live();
      t_sticky();
      t_write();
      t_bad();
      t_reset();
      summarize();
   end
   initial begin
      repeat (100000) @(posedge clock);
      mismatches++;
      summarize();
   end
endmodule
